// ===== sir_pkg.sv
// Purpose: Constants for the sequence input router.
// Assumes: AHB-Lite register access, 32-bit data, one word per register.
// Notes: Each allocation word holds four 4-bit selection digits.
// What this block does
// - Code edits allowed only when mode digit is 1
// - Each input follows its selected pin 40..46
// - Code 7 always asserted, 8 always deasserted
// - Forward overtravel: 0-6 high-active, 9-F low-active
// - Reverse overtravel uses forward overtravel encoding
// - Other inputs: 0-6 low-active, 9-F high-active
// - Shared pin drives all its inputs, each in its own slot's sense
// - Sink wiring: low pin level means ON
// - New mapping applies only after power cycle
package sir_pkg;
    // ==========================================================
    // Register map
    localparam logic [7:0] SIR_OFF_WORD_A = 8'h00;
    localparam logic [7:0] SIR_OFF_WORD_B = 8'h04;
    localparam logic [7:0] SIR_OFF_WORD_C = 8'h08;
    localparam logic [7:0] SIR_OFF_WORD_D = 8'h0c;
    localparam logic [7:0] SIR_OFF_WORD_E = 8'h10;
    localparam logic [7:0] SIR_OFF_ACTIVE = 8'h14;
    localparam logic [7:0] SIR_OFF_PINS = 8'h18;
    localparam logic [7:0] SIR_OFF_INPUTS = 8'h1c;
    // Reset values follow the shipped allocation.
    localparam logic [15:0] SIR_RST_WORD_A = 16'h2100;
    localparam logic [15:0] SIR_RST_WORD_B = 16'h6543;
    localparam logic [15:0] SIR_RST_WORD_C = 16'h8888;
    localparam logic [15:0] SIR_RST_WORD_D = 16'h8888;
    localparam logic [15:0] SIR_RST_WORD_E = 16'h8888;
    // ==========================================================
    // Selection codes
    localparam logic [3:0] SIR_CODE_PIN_LAST = 4'h6;
    localparam logic [3:0] SIR_CODE_ON = 4'h7;
    localparam logic [3:0] SIR_CODE_OFF = 4'h8;
    localparam logic [3:0] SIR_CODE_INV_BASE = 4'h9;
    localparam logic [3:0] SIR_MODE_FREE = 4'h1;
    localparam int SIR_NUM_PINS = 7;
    localparam int SIR_NUM_SIGS = 16;
    localparam int SIR_NUM_WORDS = 5;
    // Logical input index order; slot of word a digit 0 is the mode digit.
    localparam int SIR_IDX_SERVO_ON = 1;
    localparam int SIR_IDX_FWD_OT = 3;
    localparam int SIR_IDX_REV_OT = 4;
    // Bit i set: codes 0..6 mean high-level assertion (the two overtravel slots).
    localparam logic [15:0] SIR_HIGH_ACTIVE_MASK = 16'h0018;
endpackage : sir_pkg

// ===== sir_input_slot.sv
// Purpose: Decodes one selection digit into one logical input level.
// Assumes: Pin levels are already synchronised.
// Notes: Pin level 1 means low electrical level, contact closed.
`timescale 1ns/1ns
module sir_input_slot
(
    input wire logic [3:0] code,
    input wire logic high_active,
    input wire logic [sir_pkg::SIR_NUM_PINS-1:0] pin_low,
    output logic asserted
);
    import sir_pkg::*;

    logic [3:0] idx;
    logic raw_low;
    always_comb
    begin
        idx = 4'h0;
        raw_low = 1'b0;
        asserted = 1'b0;
        if (code == SIR_CODE_ON)
        begin
            asserted = 1'b1;
        end
        else if (code == SIR_CODE_OFF)
        begin
            asserted = 1'b0;
        end
        else
        begin
            if (code <= SIR_CODE_PIN_LAST)
            begin
                idx = code;
            end
            else
            begin
                idx = code - SIR_CODE_INV_BASE;
            end
            raw_low = pin_low[idx[2:0]];
            // Low-level assertion is the default sense on most inputs.
            if ((code <= SIR_CODE_PIN_LAST) == high_active)
            begin
                asserted = ~raw_low;
            end
            else
            begin
                asserted = raw_low;
            end
        end
    end
endmodule : sir_input_slot

// ===== sir_router.sv
// Purpose: Sequence input router with AHB-Lite configuration.
// Assumes: Reset models a power cycle; hresetn low reloads the mapping.
// Notes: Edited words take effect only at the next reset.
//
// The AHB-Lite interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ns
module sir_router
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [sir_pkg::SIR_NUM_PINS-1:0] io_connector_pin,
    output logic [sir_pkg::SIR_NUM_SIGS-1:0] logical_inputs
);
    import sir_pkg::*;

    // ==========================================================
    // Configuration storage
    // Saved words model non-volatile storage: they survive hresetn, which stands
    // for a power cycle, so an edited allocation can take effect afterwards.
    logic [15:0] saved_ff [SIR_NUM_WORDS] = '{SIR_RST_WORD_A, SIR_RST_WORD_B, SIR_RST_WORD_C,
        SIR_RST_WORD_D, SIR_RST_WORD_E};
    logic [15:0] active_ff [SIR_NUM_WORDS];
    logic load_pending_ff;
    logic wr_pend_ff;
    logic [7:0] wr_addr_ff;
    logic [7:0] rd_addr_ff;
    logic [31:0] nxt_hrdata;
    logic [SIR_NUM_PINS-1:0] sync1_ff;
    logic [SIR_NUM_PINS-1:0] sync2_ff;
    logic [SIR_NUM_PINS-1:0] sync3_ff;
    logic [SIR_NUM_PINS-1:0] pin_low_ff;
    logic [SIR_NUM_SIGS-1:0] slot_level;
    logic free_mode;

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign free_mode = (saved_ff[0][3:0] == SIR_MODE_FREE);

    // ==========================================================
    // AHB-Lite write address capture
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= 8'h00;
        end
        else if (hready)
        begin
            wr_pend_ff <= hsel && htrans[1] && hwrite;
            wr_addr_ff <= haddr[7:0];
        end
    end

    // Saved words: only the mode digit edits freely; codes need mode 1.
    always_ff @(posedge hclk)
    begin
        if (wr_pend_ff)
        begin
            for (int w = 0; w < SIR_NUM_WORDS; w++)
            begin
                if (wr_addr_ff == 8'(w * 4))
                begin
                    if (free_mode)
                    begin
                        saved_ff[w] <= hwdata[15:0];
                    end
                    else if (w == 0)
                    begin
                        saved_ff[0][3:0] <= hwdata[3:0];
                    end
                end
            end
        end
    end

    // Active mapping is latched once after reset release, modelling power-up.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            load_pending_ff <= 1'b1;
            for (int w = 0; w < SIR_NUM_WORDS; w++)
            begin
                active_ff[w] <= {4{SIR_CODE_OFF}};
            end
        end
        else if (load_pending_ff)
        begin
            load_pending_ff <= 1'b0;
            for (int w = 0; w < SIR_NUM_WORDS; w++)
            begin
                active_ff[w] <= saved_ff[w];
            end
        end
    end

    // ==========================================================
    // Read data
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            rd_addr_ff <= 8'h00;
        end
        else if (hready && hsel && htrans[1] && !hwrite)
        begin
            rd_addr_ff <= haddr[7:0];
        end
    end

    always_comb
    begin
        nxt_hrdata = 32'h0000_0000;
        for (int w = 0; w < SIR_NUM_WORDS; w++)
        begin
            if (rd_addr_ff == 8'(w * 4))
            begin
                nxt_hrdata = {16'h0000, saved_ff[w]};
            end
        end
        if (rd_addr_ff == SIR_OFF_ACTIVE)
        begin
            nxt_hrdata = {31'h0, load_pending_ff};
        end
        if (rd_addr_ff == SIR_OFF_PINS)
        begin
            nxt_hrdata = {25'h0, pin_low_ff};
        end
        if (rd_addr_ff == SIR_OFF_INPUTS)
        begin
            nxt_hrdata = {16'h0000, logical_inputs};
        end
    end
    assign hrdata = nxt_hrdata;

    // ==========================================================
    // Pin synchroniser; a change counts when stages two and three agree.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            // Stages start at the open-contact level, so release of reset shows no false ON on low-level-active inputs; high-level-active slots read ON until pins settle.
            sync1_ff <= '1;
            sync2_ff <= '1;
            sync3_ff <= '1;
            pin_low_ff <= '0;
        end
        else
        begin
            sync1_ff <= io_connector_pin;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
            for (int p = 0; p < SIR_NUM_PINS; p++)
            begin
                if (sync2_ff[p] == sync3_ff[p])
                begin
                    pin_low_ff[p] <= ~sync3_ff[p];
                end
            end
        end
    end

    // ==========================================================
    // Per-signal decode; slot 0 is word a digit 0, the mode digit.
    for (genvar s = 0; s < SIR_NUM_SIGS; s++)
    begin : g_slot
        if (s == 0)
        begin : g_mode
            assign slot_level[s] = 1'b0;
        end
        else
        begin : g_sig
            sir_input_slot u_slot (
                .code(active_ff[s / 4][(s % 4) * 4 +: 4]),
                .high_active(SIR_HIGH_ACTIVE_MASK[s]),
                .pin_low(pin_low_ff),
                .asserted(slot_level[s])
            );
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            logical_inputs <= '0;
        end
        else
        begin
            logical_inputs <= slot_level;
        end
    end
endmodule : sir_router

// ===== sir_host_model.sv
// Purpose: Host contacts on the router pins.
// Assumes: Sink wiring.
// Notes: Pins move only when the bench moves a contact.
`timescale 1ns/1ns
module sir_host_model
(
    input wire logic [6:0] contact_closed,
    output logic [6:0] pin_level
);
    // A closed contact pulls its pin to 0 V.
    assign pin_level = ~contact_closed;
endmodule : sir_host_model

// ===== sir_router_chk.sv
// Purpose: Assertions on the router ports.
// Assumes: Zero wait states.
// Notes: Settling allowance of eight cycles.
`timescale 1ns/1ns
module sir_router_chk
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [6:0] io_connector_pin,
    input wire logic [15:0] logical_inputs
);
    // ======
    // Checks
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic rd_ff;
    logic [7:0] ra_ff;
    logic [3:0] wm_ff;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            rd_ff <= 1'b0;
            ra_ff <= 8'h00;
            wm_ff <= 4'h0;
        end
        else
        begin
            rd_ff <= hsel && htrans[1] && hready && !hwrite && haddr[31:8] == 24'h0;
            ra_ff <= haddr[7:0];
            wm_ff <= (wm_ff == 4'hf) ? wm_ff : wm_ff + 4'h1;
        end
    end
    sequence s_calm;
        (wm_ff == 4'hf && $stable(io_connector_pin)) [*8];
    endsequence
    property p_rdy; hreadyout == 1'b1; endproperty
    property p_ok; hresp == 1'b0; endproperty
    property p_slot0; logical_inputs[0] == 1'b0; endproperty
    property p_hold; s_calm |=> $stable(logical_inputs); endproperty
    property p_pins; s_calm ##0 (rd_ff && ra_ff == 8'h18) |-> hrdata[6:0] == ~io_connector_pin;
    endproperty
    property p_outs; rd_ff && ra_ff == 8'h1c |-> hrdata[15:0] == logical_inputs; endproperty
    property p_gap; rd_ff && ra_ff >= 8'h20 |-> hrdata == 32'h0; endproperty
    property p_up; rd_ff && ra_ff <= 8'h10 |-> hrdata[31:16] == 16'h0; endproperty
    a_rdy: assert property (p_rdy) else $error("wait state");
    a_ok: assert property (p_ok) else $error("error response");
    a_slot0: assert property (p_slot0) else $error("mode slot set");
    a_hold: assert property (p_hold) else $error("inputs moved");
    a_pins: assert property (p_pins) else $error("pin levels");
    a_outs: assert property (p_outs) else $error("input readback");
    a_gap: assert property (p_gap) else $error("unmapped data");
    a_up: assert property (p_up) else $error("upper bits");
    c_gap: cover property (rd_ff && ra_ff >= 8'h20);
    c_pins: cover property (rd_ff && ra_ff == 8'h18);
    c_calm: cover property (s_calm);
endmodule : sir_router_chk
bind sir_router sir_router_chk u_chk
(
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .io_connector_pin(io_connector_pin), .logical_inputs(logical_inputs)
);

// ===== tb_sir_router.sv
// Purpose: Bench for the sequence input router.
// Assumes: Words survive reset; reset reloads the active map.
// Notes: Seed 60.
`timescale 1ns/1ns
module tb_sir_router;
    import sir_pkg::*;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [1:0] htrans = 2'b00;
    logic [2:0] hsize = 3'b010;
    logic [31:0] hrdata;
    logic rdy;
    logic [6:0] cl = 7'h00;
    logic [6:0] pins;
    logic [15:0] outs;
    logic [63:0] wo;
    logic [63:0] wn;
    logic [31:0] rd;
    int num_errors = 0;
    int tests_run = 0;
    int cyc = 0;
    initial forever #25 hclk = ~hclk;
    sir_host_model u_sir_host_model (.contact_closed(cl), .pin_level(pins));
    sir_router u_sir_router (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(rdy),
        .hrdata(hrdata), .hreadyout(rdy), .hresp(), .io_connector_pin(pins),
        .logical_inputs(outs));
    // ======
    // Tasks
    task automatic end_of_test();
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : end_of_test
    task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e)
        begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask : check
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        {hsel, htrans, hwrite, haddr} <= {1'b1, 2'b10, w, 24'h0, a};
        do @(posedge hclk); while (rdy !== 1'b1);
        {hsel, htrans, hwdata} <= {1'b0, 2'b00, d};
        do @(posedge hclk); while (rdy !== 1'b1);
        rd = hrdata;
    endtask : bus
    // Servo-on and overtravel keep their shipped polarity.
    function automatic logic [3:0] rc();
        logic [3:0] c;
        c = 4'($urandom_range(15));
        return (c > 4'h8) ? c - 4'h9 : c;
    endfunction : rc
    function automatic logic [15:0] exp_map(input logic [63:0] w, input logic [6:0] p);
        logic [15:0] r;
        logic [3:0] c;
        logic h;
        r = 16'h0;
        for (int i = 1; i < 16; i++)
        begin
            c = w[i*4 +: 4];
            // Slots 3 and 4 are the overtravel inputs, high-level active by default.
            h = (i == 3) || (i == 4);
            if (c <= 4'h6)
                r[i] = p[c[2:0]] ^ ~h;
            else if (c >= 4'h9)
                r[i] = p[int'(c) - 9] ^ h;
            else
                r[i] = (c == SIR_CODE_ON);
        end
        return r;
    endfunction : exp_map
    task automatic check_map(input logic [63:0] w);
        for (int i = 0; i < 5; i++)
        begin
            @(posedge hclk);
            cl <= (i == 0) ? 7'h00 : (i == 1) ? 7'h7f : 7'($urandom);
            repeat (9) @(posedge hclk);
            check("inputs", {16'h0, outs}, {16'h0, exp_map(w, ~cl)});
            bus(1'b0, SIR_OFF_PINS, 32'h0);
            check("pins", rd & 32'h7f, {25'h0, cl});
        end
    endtask : check_map
    always @(posedge hclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            num_errors++;
            end_of_test();
        end
    end
    initial
    begin
        void'($urandom(60));
        wo = {SIR_RST_WORD_D, SIR_RST_WORD_C, SIR_RST_WORD_B, SIR_RST_WORD_A};
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        for (int i = 0; i < 5; i++)
        begin
            bus(1'b0, 8'(i * 4), 32'h0);
            check("reset", rd, {16'h0, (i < 4) ? wo[i*16 +: 16] : SIR_RST_WORD_E});
        end
        bus(1'b0, 8'h24, 32'h0);
        check("unmapped", rd, 32'h0);
        bus(1'b0, SIR_OFF_ACTIVE, 32'h0);
        check("load", rd, 32'h0);
        bus(1'b1, SIR_OFF_WORD_B, 32'h0);
        bus(1'b0, SIR_OFF_WORD_B, 32'h0);
        check("locked", rd, {16'h0, SIR_RST_WORD_B});
        check_map(wo);
        repeat (2)
        begin
            wn = {$urandom, $urandom};
            {wn[19:16], wn[15:12], wn[7:4], wn[3:0]} = {rc(), rc(), rc(), SIR_MODE_FREE};
            {wn[39:36], wn[35:32], wn[63:60]} = {SIR_CODE_OFF, SIR_CODE_ON, wn[7:4]};
            bus(1'b1, SIR_OFF_WORD_A, {16'h0, wo[15:4], SIR_MODE_FREE});
            for (int i = 0; i < 4; i++)
                bus(1'b1, 8'(i * 4), {16'h0, wn[i*16 +: 16]});
            for (int i = 0; i < 4; i++)
            begin
                bus(1'b0, 8'(i * 4), 32'h0);
                check("word", rd, {16'h0, wn[i*16 +: 16]});
            end
            check_map(wo);
            bus(1'b0, SIR_OFF_INPUTS, 32'h0);
            check("readback", rd, {16'h0, exp_map(wo, ~cl)});
            hresetn <= 1'b0;
            repeat (3) @(posedge hclk);
            hresetn <= 1'b1;
            wo = wn;
            check_map(wo);
        end
        end_of_test();
    end
endmodule : tb_sir_router
